// ### rtl/regulator_link_pkg.sv
// Contract
// (R1) start/stop are data edges while clock high
// (R2) transactions framed by start and stop
// (R3) stop during read ends it, to standby
// (R4) stop during write commits data, then standby
// (R5) host never issues back-to-back starts
// (R6) host changes data only while clock low
// (R7) device answers only address 1001111
// (R8) on/off bit: 0 on, 1 off
// (R9) switcher level: 4-bit code, 16 steps
// (R10) five linear channels, own 4-bit level
// (R11) discharge value bit: 0 low, 1 high
// (R12) discharge enable bit: 0 off, 1 on
// (R13) linear 1-4 follow pin or register bit
// (R14) active-low reset input resets control logic
// (R15) write: address, index, data; read via restart
package regulator_link_pkg;

	// ----------------------------------------
	// serial link
	// ----------------------------------------
	localparam logic [6:0] DEV_ADDR = 7'h4F;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	// ----------------------------------------
	// device register bank
	// ----------------------------------------
	localparam int REG_COUNT = 10;
	localparam logic [7:0] REG_COUNT_B = 8'h0A;
	localparam logic [3:0] IDX_ON_OFF = 4'h0;
	localparam logic [3:0] IDX_SW_LEVEL = 4'h1;
	localparam logic [3:0] IDX_LIN_LEVEL = 4'h2;
	localparam logic [3:0] IDX_DIS_VALUE = 4'h7;
	localparam logic [3:0] IDX_DIS_ON = 4'h8;
	localparam logic [3:0] IDX_EN_SRC = 4'h9;
	localparam int LIN_CHANNELS = 5;
	localparam int PIN_CHANNELS = 4;
	// bits above a register's width store and read as zero
	localparam logic [9:0][7:0] REG_MASK = {8'h0F, 8'h3F, 8'h3F, 8'h0F, 8'h0F,
		8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h3F};
	// all on/off bits set to off, linear 1-4 follow their pins, everything else zero
	localparam logic [9:0][7:0] REG_RESET = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h3F};

	typedef enum {
		DS_IDLE, DS_ADDR, DS_INDEX, DS_WDATA, DS_ACK, DS_RDATA, DS_RACK
	} dev_state_e;

	// ----------------------------------------
	// host command registers
	// ----------------------------------------
	localparam logic [7:0] HOST_CMD_OFS = 8'h00;
	localparam logic [7:0] HOST_STATUS_OFS = 8'h04;
	localparam int CMD_DATA_LSB = 0;
	localparam int CMD_INDEX_LSB = 8;
	localparam int CMD_READ_BIT = 16;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_NACK_BIT = 1;
	localparam int ST_RDATA_LSB = 8;

	// ----------------------------------------
	// host timing
	// ----------------------------------------
	localparam int SYS_CLK_MHZ = 100;
	localparam int SCL_QUARTER_NS = 1250;
	localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam logic [7:0] QTR_LAST = 8'(SCL_QUARTER_CYC - 1);

	typedef enum {
		HS_IDLE, HS_START, HS_ADDRW, HS_INDEX, HS_DATA, HS_RESTART, HS_ADDRR,
		HS_READ, HS_STOP
	} host_state_e;

endpackage

// ### rtl/regulator_link_if.sv
`timescale 1ns/100ps
// ----------------------------------------
// two-wire link between host and device
// ----------------------------------------
interface regulator_link_if;
	logic scl;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic sda;

	// pulled-up data line, any enabled driver sending low wins
	assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

	modport host (
		output scl,
		output host_sda_o,
		output host_sda_oe,
		input sda
	);

	modport device (
		input scl,
		input sda,
		output dev_sda_o,
		output dev_sda_oe
	);
endinterface

// ### rtl/regulator_ctrl_device.sv
// The AHB-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
// ----------------------------------------
// device end: serial slave and control bank
// ----------------------------------------
module regulator_ctrl_device (
	input wire logic link_clk,
	input wire logic reset_in_n,
	input wire logic linear1_enable_pin,
	input wire logic linear2_enable_pin,
	input wire logic linear3_enable_pin,
	input wire logic linear4_enable_pin,
	regulator_link_if.device link,
	output logic switcher_on,
	output logic [4:0] linear_on,
	output logic [3:0] switcher_level,
	output logic [4:0][3:0] linear_level,
	output logic switcher_discharge_value,
	output logic [4:0] linear_discharge_value,
	output logic switcher_discharge_on,
	output logic [4:0] linear_discharge_on,
	output logic [3:0] linear_enable_source
);

	typedef struct packed {
		logic [1:0] rst_sync;
		logic [1:0] scl_sync;
		logic [1:0] sda_sync;
		logic [3:0][1:0] pin_sync;
		logic scl_prev;
		logic sda_prev;
		regulator_link_pkg::dev_state_e state;
		regulator_link_pkg::dev_state_e nxt;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] idx;
		logic pend;
		logic [7:0] pend_idx;
		logic [7:0] pend_data;
		logic sda_oe;
		logic [9:0][7:0] regs;
		logic [5:0] chan_on;
	} dev_s;

	dev_s q;
	dev_s d;
	logic [3:0] pins;
	logic scl;
	logic sda;
	logic rise;
	logic fall;
	logic start_ev;
	logic stop_ev;
	logic [7:0] rd_byte;

	assign pins = {linear4_enable_pin, linear3_enable_pin, linear2_enable_pin,
		linear1_enable_pin};

	// ----------------------------------------
	// bus events, all from the second sync stage
	// ----------------------------------------
	assign scl = q.scl_sync[1];
	assign sda = q.sda_sync[1];
	assign rise = scl && !q.scl_prev;
	assign fall = !scl && q.scl_prev;
	// data edge while the clock stays high marks framing
	assign start_ev = scl && q.scl_prev && q.sda_prev && !sda; // R1
	assign stop_ev = scl && q.scl_prev && !q.sda_prev && sda; // R1

	// unmapped indexes read as zero
	assign rd_byte = (q.idx < regulator_link_pkg::REG_COUNT_B) ? q.regs[q.idx[3:0]] : 8'h00;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		d = q;
		// first stages only ever feed the second
		d.rst_sync = {q.rst_sync[0], reset_in_n};
		d.scl_sync = {q.scl_sync[0], link.scl};
		d.sda_sync = {q.sda_sync[0], link.sda};
		for (int i = 0; i < regulator_link_pkg::PIN_CHANNELS; i++) begin
			d.pin_sync[i] = {q.pin_sync[i][0], pins[i]};
		end
		d.scl_prev = scl;
		d.sda_prev = sda;
		if (q.rst_sync[1]) begin
			if (stop_ev) begin
				// read or write both end here; a pending write lands first
				d.state = regulator_link_pkg::DS_IDLE; // R3
				d.sda_oe = 1'b0;
				d.pend = 1'b0;
				if (q.pend && q.pend_idx < regulator_link_pkg::REG_COUNT_B) begin
					d.regs[q.pend_idx[3:0]] = q.pend_data
						& regulator_link_pkg::REG_MASK[q.pend_idx[3:0]]; // R4
				end
			end else if (start_ev) begin
				// a repeated start is taken like a first one
				d.state = regulator_link_pkg::DS_ADDR; // R2
				d.cnt = 4'h0;
				d.sda_oe = 1'b0;
			end else begin
				case (q.state)
					regulator_link_pkg::DS_IDLE: begin
						// anything outside a frame is ignored
						d.sda_oe = 1'b0; // R2
					end
					regulator_link_pkg::DS_ADDR,
					regulator_link_pkg::DS_INDEX,
					regulator_link_pkg::DS_WDATA: begin
						if (rise && q.cnt < regulator_link_pkg::BYTE_BITS) begin
							d.sh = {q.sh[6:0], sda};
							d.cnt = q.cnt + 4'h1;
						end else if (fall && q.cnt == regulator_link_pkg::BYTE_BITS) begin
							d.cnt = 4'h0;
							d.state = regulator_link_pkg::DS_ACK;
							d.sda_oe = 1'b1;
							if (q.state == regulator_link_pkg::DS_ADDR) begin
								if (q.sh[7:1] == regulator_link_pkg::DEV_ADDR) begin
									d.nxt = q.sh[0] ? regulator_link_pkg::DS_RDATA
										: regulator_link_pkg::DS_INDEX; // R15
								end else begin
									// not ours: stay silent until the next frame
									d.state = regulator_link_pkg::DS_IDLE; // R7
									d.sda_oe = 1'b0;
								end
							end else if (q.state == regulator_link_pkg::DS_INDEX) begin
								d.idx = q.sh; // R15
								d.nxt = regulator_link_pkg::DS_WDATA;
							end else if (!q.pend) begin
								// held back until the next stop, even past a repeated start; reset drops it, and so does a stop when its index is unmapped
								d.pend = 1'b1; // R4
								d.pend_idx = q.idx;
								d.pend_data = q.sh;
								d.nxt = regulator_link_pkg::DS_WDATA;
							end else begin
								// only one data byte per write; extras get no ack
								d.state = regulator_link_pkg::DS_IDLE;
								d.sda_oe = 1'b0;
							end
						end
					end
					regulator_link_pkg::DS_ACK: begin
						if (fall) begin
							d.sda_oe = 1'b0;
							d.state = q.nxt;
							if (q.nxt == regulator_link_pkg::DS_RDATA) begin
								d.sh = rd_byte;
								d.sda_oe = !rd_byte[7];
								d.cnt = 4'h1;
							end
						end
					end
					regulator_link_pkg::DS_RDATA: begin
						if (fall) begin
							if (q.cnt == regulator_link_pkg::BYTE_BITS) begin
								d.sda_oe = 1'b0;
								d.state = regulator_link_pkg::DS_RACK;
							end else begin
								d.sh = {q.sh[6:0], 1'b0};
								d.sda_oe = !q.sh[6];
								d.cnt = q.cnt + 4'h1;
							end
						end
					end
					regulator_link_pkg::DS_RACK: begin
						if (rise) begin
							if (sda) begin
								// host declined more: idle till stop
								d.state = regulator_link_pkg::DS_IDLE; // R3
							end else begin
								d.idx = q.idx + 8'h01;
								d.state = regulator_link_pkg::DS_ACK;
								d.nxt = regulator_link_pkg::DS_RDATA;
							end
						end
					end
					default: begin
						d.state = regulator_link_pkg::DS_IDLE;
						d.sda_oe = 1'b0;
					end
				endcase
			end
		end else begin
			// held in reset while the pin stays low
			d.state = regulator_link_pkg::DS_IDLE; // R14
			d.nxt = regulator_link_pkg::DS_IDLE;
			d.cnt = 4'h0;
			d.sh = 8'h00;
			d.idx = 8'h00;
			d.pend = 1'b0;
			d.pend_idx = 8'h00;
			d.pend_data = 8'h00;
			d.sda_oe = 1'b0;
			d.regs = regulator_link_pkg::REG_RESET; // R14
		end
		// on when the bit is 0; linear 1-4 may follow their pins instead
		d.chan_on[0] = !q.regs[regulator_link_pkg::IDX_ON_OFF][0]; // R8
		for (int i = 1; i <= regulator_link_pkg::LIN_CHANNELS; i++) begin
			d.chan_on[i] = !q.regs[regulator_link_pkg::IDX_ON_OFF][i]; // R8
			if (i <= regulator_link_pkg::PIN_CHANNELS) begin
				if (!q.regs[regulator_link_pkg::IDX_EN_SRC][i - 1]) begin
					d.chan_on[i] = q.pin_sync[i - 1][1]; // R13
				end
			end
		end
		if (!q.rst_sync[1]) begin
			d.chan_on = 6'h00;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge link_clk) begin
		q <= d;
	end

	// ----------------------------------------
	// outputs, all from flops but the data level, tied low
	// ----------------------------------------
	assign link.dev_sda_o = 1'b0;
	assign link.dev_sda_oe = q.sda_oe;
	assign switcher_on = q.chan_on[0];
	assign linear_on = q.chan_on[5:1];
	assign switcher_level = q.regs[regulator_link_pkg::IDX_SW_LEVEL][3:0]; // R9
	// one level register per linear channel
	for (genvar g = 0; g < regulator_link_pkg::LIN_CHANNELS; g++) begin : g_lvl
		assign linear_level[g] = q.regs[regulator_link_pkg::IDX_LIN_LEVEL + 4'(g)][3:0]; // R10
	end
	assign switcher_discharge_value = q.regs[regulator_link_pkg::IDX_DIS_VALUE][0]; // R11
	assign linear_discharge_value = q.regs[regulator_link_pkg::IDX_DIS_VALUE][5:1]; // R11
	assign switcher_discharge_on = q.regs[regulator_link_pkg::IDX_DIS_ON][0]; // R12
	assign linear_discharge_on = q.regs[regulator_link_pkg::IDX_DIS_ON][5:1]; // R12
	assign linear_enable_source = q.regs[regulator_link_pkg::IDX_EN_SRC][3:0]; // R13

endmodule

// ### rtl/regulator_ctrl_host.sv
`timescale 1ns/100ps
// ----------------------------------------
// host end: AHB-Lite command port, link master
// ----------------------------------------
module regulator_ctrl_host (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	regulator_link_if.host link
);

	typedef struct packed {
		logic [1:0] sda_sync;
		regulator_link_pkg::host_state_e st;
		logic [1:0] qtr;
		logic [7:0] tick;
		logic [3:0] bitn;
		logic [8:0] sh;
		logic [7:0] rx;
		logic ack_bad;
		logic [16:0] cmd;
		logic busy;
		logic nack;
		logic scl;
		logic sda_lvl;
		logic ap_valid;
		logic ap_write;
		logic [7:0] ap_addr;
		logic [31:0] rdata;
	} host_s;

	host_s q;
	host_s d;
	logic accept;
	logic [1:0] nq;
	logic [8:0] nsh;
	regulator_link_pkg::host_state_e nst;

	// clock and data levels for one quarter of an element
	function automatic logic [1:0] wave(regulator_link_pkg::host_state_e s,
		logic [1:0] qq, logic b);
		logic hi;
		hi = (qq == 2'd1) || (qq == 2'd2);
		case (s)
			regulator_link_pkg::HS_START,
			regulator_link_pkg::HS_RESTART: wave = {hi, qq < 2'd2}; // R1
			regulator_link_pkg::HS_STOP: wave = {qq != 2'd0, qq >= 2'd2}; // R1
			// idle bus rests with both lines high, never clock low after a stop
			regulator_link_pkg::HS_IDLE: wave = 2'b11; // R2
			default: wave = {hi, b}; // R6
		endcase
	endfunction

	assign accept = hsel && hready && htrans[1];
	assign nq = q.qtr + 2'd1;
	assign nsh = {q.sh[7:0], 1'b1};

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		d = q;
		nst = q.st;
		d.sda_sync = {q.sda_sync[0], link.sda};
		// bus address phase: read data prepared here, shown in data phase
		d.ap_valid = accept;
		d.ap_write = hwrite;
		d.ap_addr = haddr[7:0];
		if (accept && !hwrite) begin
			d.rdata = 32'h0000_0000;
			if (haddr[7:0] == regulator_link_pkg::HOST_CMD_OFS) begin
				d.rdata[16:0] = q.cmd;
			end else if (haddr[7:0] == regulator_link_pkg::HOST_STATUS_OFS) begin
				d.rdata[regulator_link_pkg::ST_BUSY_BIT] = q.busy;
				d.rdata[regulator_link_pkg::ST_NACK_BIT] = q.nack;
				d.rdata[regulator_link_pkg::ST_RDATA_LSB +: 8] = q.rx;
			end
		end
		if (q.busy) begin
			if (q.tick == regulator_link_pkg::QTR_LAST) begin
				d.tick = 8'h00;
				d.qtr = nq;
				// sample the line after clock has been high a quarter
				if (nq == 2'd2) begin
					if (q.st == regulator_link_pkg::HS_READ
						&& q.bitn < regulator_link_pkg::BYTE_BITS) begin
						d.rx = {q.rx[6:0], q.sda_sync[1]};
					end
					d.ack_bad = q.sda_sync[1];
				end
				if (q.qtr == 2'd3) begin
					// element done: next bit, or next step of the frame
					if (q.st != regulator_link_pkg::HS_START
						&& q.st != regulator_link_pkg::HS_RESTART
						&& q.st != regulator_link_pkg::HS_STOP
						&& q.bitn < regulator_link_pkg::BYTE_BITS) begin
						d.sh = nsh;
						d.bitn = q.bitn + 4'h1;
					end else begin
						d.bitn = 4'h0;
						case (q.st)
							regulator_link_pkg::HS_START: begin
								nst = regulator_link_pkg::HS_ADDRW; // R15
								d.sh = {regulator_link_pkg::DEV_ADDR, 2'b01};
							end
							regulator_link_pkg::HS_ADDRW: begin
								nst = regulator_link_pkg::HS_INDEX; // R15
								d.sh = {q.cmd[regulator_link_pkg::CMD_INDEX_LSB +: 8], 1'b1};
							end
							regulator_link_pkg::HS_INDEX: begin
								// restart only after a byte, never two starts in a row
								nst = q.cmd[regulator_link_pkg::CMD_READ_BIT]
									? regulator_link_pkg::HS_RESTART
									: regulator_link_pkg::HS_DATA; // R5
								d.sh = {q.cmd[regulator_link_pkg::CMD_DATA_LSB +: 8], 1'b1};
							end
							regulator_link_pkg::HS_RESTART: begin
								nst = regulator_link_pkg::HS_ADDRR;
								d.sh = {regulator_link_pkg::DEV_ADDR, 2'b11};
							end
							regulator_link_pkg::HS_ADDRR: begin
								nst = regulator_link_pkg::HS_READ;
								d.sh = 9'h1FF; // released bits, then no-ack
							end
							regulator_link_pkg::HS_STOP: begin
								nst = regulator_link_pkg::HS_IDLE;
								d.busy = 1'b0;
							end
							default: begin
								nst = regulator_link_pkg::HS_STOP; // R2
							end
						endcase
						// a refused byte aborts the frame with a stop
						if (q.ack_bad && q.st != regulator_link_pkg::HS_READ
							&& q.st != regulator_link_pkg::HS_START
							&& q.st != regulator_link_pkg::HS_RESTART
							&& q.st != regulator_link_pkg::HS_STOP) begin
							nst = regulator_link_pkg::HS_STOP;
							d.nack = 1'b1;
						end
						d.st = nst;
					end
				end
				{d.scl, d.sda_lvl} = wave(nst, nq, (q.qtr == 2'd3) ? d.sh[8] : q.sh[8]);
			end else begin
				d.tick = q.tick + 8'h01;
			end
		end else if (q.ap_valid && q.ap_write
			&& q.ap_addr == regulator_link_pkg::HOST_CMD_OFS) begin
			// command write launches a frame; ignored while busy
			d.cmd = hwdata[16:0];
			d.busy = 1'b1;
			d.nack = 1'b0;
			d.st = regulator_link_pkg::HS_START; // R2
			d.qtr = 2'd0;
			d.tick = 8'h00;
			d.bitn = 4'h0;
			d.ack_bad = 1'b0;
			d.scl = 1'b0;
			d.sda_lvl = 1'b1;
		end
		if (sys_rst) begin
			d.st = regulator_link_pkg::HS_IDLE;
			d.qtr = 2'd0;
			d.tick = 8'h00;
			d.bitn = 4'h0;
			d.sh = 9'h1FF;
			d.rx = 8'h00;
			d.ack_bad = 1'b0;
			d.cmd = 17'h0_0000;
			d.busy = 1'b0;
			d.nack = 1'b0;
			d.scl = 1'b1;
			d.sda_lvl = 1'b1;
			d.ap_valid = 1'b0;
			d.ap_write = 1'b0;
			d.ap_addr = 8'h00;
			d.rdata = 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		q <= d;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign hreadyout = 1'b1; // zero wait states
	assign hresp = 1'b0;
	assign hrdata = q.rdata;
	assign link.scl = q.scl;
	assign link.host_sda_o = 1'b0;
	assign link.host_sda_oe = !q.sda_lvl; // open drain: drive only low

endmodule

// ### tb/regulator_link_chk.sv
`timescale 1ns/100ps
// ----------------------------------------
// link checker: host and device wire behaviour
// ----------------------------------------
module regulator_link_chk (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic link_clk,
	input wire logic reset_in_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe
);

	// host side, sampled on the system clock
	host_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$fell(sys_rst) |-> scl && !host_sda_oe)
		else $error("link not idle after host reset");
	scl_high_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(scl) |-> scl [*8])
		else $error("clock high phase too short");
	scl_low_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$fell(scl) |-> !scl [*8])
		else $error("clock low phase too short");
	// a start pulls data low with clock high, clock falls one quarter later
	start_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		scl && $rose(host_sda_oe) |-> ##[100:130] !scl)
		else $error("start not followed by clock low");
	// a stop releases data with clock high and the clock then stays high for at least 8 cycles
	stop_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		scl && $fell(host_sda_oe) |-> scl [*8])
		else $error("clock moved right after stop");

	// device side, sampled on the link clock
	dev_quiet_a: assert property (@(posedge link_clk) disable iff (!reset_in_n)
		$rose(reset_in_n) |-> !dev_sda_oe [*3])
		else $error("device drives data out of reset");
	dev_change_a: assert property (@(posedge link_clk) disable iff (!reset_in_n)
		$changed(dev_sda_oe) |-> !scl)
		else $error("device changed data with clock high");
	dev_yield_a: assert property (@(posedge link_clk) disable iff (!reset_in_n)
		dev_sda_oe && scl |-> !host_sda_oe)
		else $error("host and device both drive data");
	ack_hold_a: assert property (@(posedge link_clk) disable iff (!reset_in_n)
		$rose(dev_sda_oe) |-> dev_sda_oe [*8])
		else $error("device drive too short");

	// main link events seen at least once
	start_c: cover property (@(posedge sys_clk) disable iff (sys_rst) scl && $fell(sda));
	stop_c: cover property (@(posedge sys_clk) disable iff (sys_rst) scl && $rose(sda));
	dev_ack_c: cover property (@(posedge link_clk) disable iff (!reset_in_n)
		$rose(dev_sda_oe));

endmodule

// ### tb/regulator_control_serial_regs_tb_top.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
	$display("[FAIL] %0t got %h expected %h", $time, got, exp); end end

module regulator_control_serial_regs_tb_top;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic link_clk = 1'b0;
	logic reset_in_n = 1'b0;
	logic [3:0] pins = 4'h0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hready;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic switcher_on;
	logic [4:0] linear_on;
	logic [3:0] switcher_level;
	logic [4:0][3:0] linear_level;
	logic switcher_discharge_value;
	logic [4:0] linear_discharge_value;
	logic switcher_discharge_on;
	logic [4:0] linear_discharge_on;
	logic [3:0] linear_enable_source;
	logic [31:0] st;
	int failures = 0;
	int check_count = 0;

	// ----------------------------------------
	// clocks, bus and design ends
	// ----------------------------------------
	always #5 sys_clk = ~sys_clk;
	// 32 ns link clock period is not a multiple of the 10 ns system clock period
	always #16 link_clk = ~link_clk;
	// single slave: its ready is the bus ready
	assign hready = hreadyout;

	regulator_link_if link_if ();

	regulator_ctrl_host u_regulator_ctrl_host (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(3'h2),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.link(link_if)
	);

	regulator_ctrl_device u_regulator_ctrl_device (
		.link_clk(link_clk),
		.reset_in_n(reset_in_n),
		.linear1_enable_pin(pins[0]),
		.linear2_enable_pin(pins[1]),
		.linear3_enable_pin(pins[2]),
		.linear4_enable_pin(pins[3]),
		.link(link_if),
		.switcher_on(switcher_on),
		.linear_on(linear_on),
		.switcher_level(switcher_level),
		.linear_level(linear_level),
		.switcher_discharge_value(switcher_discharge_value),
		.linear_discharge_value(linear_discharge_value),
		.switcher_discharge_on(switcher_discharge_on),
		.linear_discharge_on(linear_discharge_on),
		.linear_enable_source(linear_enable_source)
	);

	regulator_link_chk u_regulator_link_chk (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.link_clk(link_clk),
		.reset_in_n(reset_in_n),
		.scl(link_if.scl),
		.sda(link_if.sda),
		.host_sda_oe(link_if.host_sda_oe),
		.dev_sda_oe(link_if.dev_sda_oe)
	);

	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task test_done();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// bounded wait for bus ready at a rising edge
	task wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (hready !== 1'b1 && n < 1000);
		if (n >= 1000) begin
			failures++;
			$display("[FAIL] %0t bus ready timeout", $time);
			test_done();
		end
	endtask

	task ahb_xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge sys_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, ofs};
		hwrite <= wr;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
		`CHK(hresp, 1'b0)
	endtask

	// one link command, a refused second command, then poll until idle
	task run_cmd(input logic rd, input logic [7:0] idx, input logic [7:0] d);
		int n;
		logic [31:0] cmd;
		logic [31:0] r;
		cmd = {15'h0, rd, idx, d};
		ahb_xfer(1'b1, regulator_link_pkg::HOST_CMD_OFS, cmd, r);
		ahb_xfer(1'b0, regulator_link_pkg::HOST_STATUS_OFS, 32'h0, st);
		`CHK(st[regulator_link_pkg::ST_BUSY_BIT], 1'b1)
		ahb_xfer(1'b1, regulator_link_pkg::HOST_CMD_OFS, 32'h0000_0955, r);
		ahb_xfer(1'b0, regulator_link_pkg::HOST_CMD_OFS, 32'h0, r);
		`CHK(r, cmd)
		n = 0;
		// a read frame is under 20000 cycles; each poll takes three
		while (st[regulator_link_pkg::ST_BUSY_BIT] !== 1'b0 && n < 8000) begin
			ahb_xfer(1'b0, regulator_link_pkg::HOST_STATUS_OFS, 32'h0, st);
			n++;
		end
		if (n >= 8000) begin
			failures++;
			$display("[FAIL] %0t link frame timeout", $time);
			test_done();
		end
		`CHK(st[regulator_link_pkg::ST_NACK_BIT], 1'b0)
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		reset_in_n <= 1'b1;
		// device needs a few link edges after its reset lifts
		repeat (40) @(posedge sys_clk);
		`CHK(switcher_on, 1'b0)
		`CHK(linear_on, 5'h00)
		`CHK(switcher_level, 4'h0)
		`CHK(linear_level, 20'h00000)
		`CHK({switcher_discharge_value, linear_discharge_value}, 6'h00)
		`CHK({switcher_discharge_on, linear_discharge_on}, 6'h00)
		`CHK(linear_enable_source, 4'h0)
		ahb_xfer(1'b0, 8'h08, 32'h0, st);
		`CHK(st, 32'h0)
		pins <= 4'h5;
		repeat (10) @(posedge link_clk);
		`CHK(linear_on, 5'h05)
		$display("test reset and pins done");
		run_cmd(1'b0, {4'h0, regulator_link_pkg::IDX_ON_OFF}, 8'h00);
		`CHK(switcher_on, 1'b1)
		`CHK(linear_on, 5'h15)
		$display("test on/off write done");
		pins <= 4'h0;
		run_cmd(1'b0, {4'h0, regulator_link_pkg::IDX_EN_SRC}, 8'h0F);
		`CHK(linear_enable_source, 4'hF)
		`CHK(linear_on, 5'h1F)
		$display("test enable source done");
		run_cmd(1'b0, {4'h0, regulator_link_pkg::IDX_SW_LEVEL}, 8'hFF);
		`CHK(switcher_level, 4'hF)
		run_cmd(1'b0, {4'h0, regulator_link_pkg::IDX_DIS_VALUE}, 8'h2A);
		`CHK(switcher_discharge_value, 1'b0)
		`CHK(linear_discharge_value, 5'h15)
		$display("test level and discharge done");
		run_cmd(1'b1, {4'h0, regulator_link_pkg::IDX_SW_LEVEL}, 8'h00);
		`CHK(st[15:8], 8'h0F)
		$display("test read back done");
		@(posedge link_clk);
		reset_in_n <= 1'b0;
		repeat (5) @(posedge link_clk);
		reset_in_n <= 1'b1;
		repeat (8) @(posedge link_clk);
		`CHK(switcher_level, 4'h0)
		`CHK(switcher_on, 1'b0)
		$display("test device reset done");
		test_done();
	end
endmodule
